// file: rtl/fcs_sequencer.sv
// Floppy command sequencer: command, execution and result phases behind an
// AXI4-Lite register port, with head stepping toward one of four drives.
// Assumes a single 100 MHz clock, synchronous drive inputs, one master.
`timescale 1ns/10ps
module fcs_sequencer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire fcs_pkg::fcs_axi_req_t axi_req,
   output fcs_pkg::fcs_axi_rsp_t axi_rsp,
   input wire fcs_pkg::fcs_drive_in_t drive_in,
   output fcs_pkg::fcs_drive_out_t drive_out,
   output logic irq
);
   fcs_pkg::fcs_state_t st;       // Registered state
   fcs_pkg::fcs_state_t next_st;  // Next state
   logic wr_take;                 // Write address and data taken together
   logic rd_take;                 // Read address taken
   logic host_byte_ok;            // Sequencer wants a data byte
   logic data_wr;                 // Byte written into the data register
   logic data_rd;                 // Result byte popped

   // Opcode to command; shared by the byte decode and the assertions
   function automatic fcs_pkg::fcs_cmd_t fcs_decode(input logic [7:0] b);
      fcs_pkg::fcs_cmd_t c;
      c = fcs_pkg::CMD_INVALID;
      if (b[4:0] == fcs_pkg::OP_FORMAT && b[7] == 1'b0 && b[5] == 1'b0) begin
         c = fcs_pkg::CMD_FORMAT;
      end else if (b[6:0] == fcs_pkg::OP_LOCK) begin
         c = fcs_pkg::CMD_LOCK;
      end else begin
         case (b)
            fcs_pkg::OP_RECAL: c = fcs_pkg::CMD_RECAL;
            fcs_pkg::OP_SENSE_INT: c = fcs_pkg::CMD_SENSE_INT;
            fcs_pkg::OP_SPECIFY: c = fcs_pkg::CMD_SPECIFY;
            fcs_pkg::OP_SEEK: c = fcs_pkg::CMD_SEEK;
            fcs_pkg::OP_CONFIGURE: c = fcs_pkg::CMD_CONFIGURE;
            fcs_pkg::OP_DUMPREG: c = fcs_pkg::CMD_DUMPREG;
            fcs_pkg::OP_PERP: c = fcs_pkg::CMD_PERP;
            fcs_pkg::OP_SENSE_DRIVE: c = fcs_pkg::CMD_SENSE_DRIVE;
            default: c = fcs_pkg::CMD_INVALID;
         endcase
      end
      return c;
   endfunction : fcs_decode

   // Parameter bytes that follow the opcode
   function automatic logic [2:0] fcs_param_count(input fcs_pkg::fcs_cmd_t c);
      logic [2:0] n;
      case (c)
         fcs_pkg::CMD_FORMAT: n = 3'd5;
         fcs_pkg::CMD_CONFIGURE: n = 3'd3;
         fcs_pkg::CMD_SEEK, fcs_pkg::CMD_SPECIFY: n = 3'd2;
         fcs_pkg::CMD_RECAL, fcs_pkg::CMD_PERP, fcs_pkg::CMD_SENSE_DRIVE: n = 3'd1;
         default: n = 3'd0;
      endcase
      return n;
   endfunction : fcs_param_count

   // Bus handshakes; write waits for both channels so they pair naturally
   assign wr_take = axi_req.awvalid & axi_req.wvalid & ~st.bvalid;
   assign rd_take = axi_req.arvalid & ~st.rvalid;
   assign host_byte_ok = (st.phase == fcs_pkg::PH_IDLE) | (st.phase == fcs_pkg::PH_PARAM) |
                         (st.phase == fcs_pkg::PH_FMT);
   assign data_wr = wr_take & (axi_req.awaddr == fcs_pkg::OFF_DATA) & axi_req.wstrb[0] & host_byte_ok;
   assign data_rd = rd_take & (axi_req.araddr == fcs_pkg::OFF_DATA) & (st.phase == fcs_pkg::PH_RESULT);

   // Slave outputs; ready terms are combinational, data comes from flops
   assign axi_rsp.awready = wr_take;
   assign axi_rsp.wready = wr_take;
   assign axi_rsp.bvalid = st.bvalid;
   assign axi_rsp.bresp = st.bresp;
   assign axi_rsp.arready = rd_take;
   assign axi_rsp.rvalid = st.rvalid;
   assign axi_rsp.rdata = {24'h000000, st.rdata};
   assign axi_rsp.rresp = st.rresp;
   assign drive_out.step = st.step;
   assign drive_out.dir = st.dir;
   assign drive_out.head_select = st.head;
   assign drive_out.drive_select = st.drv;
   assign irq = |(st.int_status & st.int_mask);

   // All next-state logic
   always_comb begin
      logic [1:0] ev;      // Events raised this cycle
      logic [1:0] w1c;     // Status bits cleared by software
      logic [7:0] pc;      // Cylinder of the selected drive
      ev = 2'h0;
      w1c = 2'h0;
      pc = st.present_cylinder_number[st.drv];
      next_st = st;
      next_st.step = 1'b0;

      // Write response channel
      if (st.bvalid && axi_req.bready) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_take) begin
         next_st.bvalid = 1'b1;
         next_st.bresp = fcs_pkg::RESP_OKAY;
         case (axi_req.awaddr)
            fcs_pkg::OFF_DATA, fcs_pkg::OFF_MAIN_STATUS: begin
               // Data byte handled by the phase logic; status is read only
            end
            fcs_pkg::OFF_INT_STATUS: begin
               if (axi_req.wstrb[0]) w1c = axi_req.wdata[1:0];
            end
            fcs_pkg::OFF_INT_MASK: begin
               if (axi_req.wstrb[0]) next_st.int_mask = axi_req.wdata[1:0];
            end
            default: next_st.bresp = fcs_pkg::RESP_SLVERR;
         endcase
      end

      // Read channel; data register pops only while results wait
      if (st.rvalid && axi_req.rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_take) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = fcs_pkg::RESP_OKAY;
         next_st.rdata = 8'h00;
         case (axi_req.araddr)
            fcs_pkg::OFF_DATA: begin
               if (st.phase == fcs_pkg::PH_RESULT) next_st.rdata = st.res[st.res_idx];
            end
            fcs_pkg::OFF_MAIN_STATUS: begin
               next_st.rdata[fcs_pkg::MSR_RQM] = host_byte_ok | (st.phase == fcs_pkg::PH_RESULT);
               next_st.rdata[fcs_pkg::MSR_DIO] = (st.phase == fcs_pkg::PH_RESULT);
               next_st.rdata[fcs_pkg::MSR_BUSY] = (st.phase != fcs_pkg::PH_IDLE);
            end
            fcs_pkg::OFF_INT_STATUS: next_st.rdata = {6'h00, st.int_status};
            fcs_pkg::OFF_INT_MASK: next_st.rdata = {6'h00, st.int_mask};
            default: next_st.rresp = fcs_pkg::RESP_SLVERR;
         endcase
      end

      // Command sequencing
      case (st.phase)
         fcs_pkg::PH_IDLE: begin
            if (data_wr) begin
               next_st.opbyte = axi_req.wdata[7:0];
               next_st.cmd = fcs_decode(axi_req.wdata[7:0]);
               next_st.pidx = 3'd0;
               if (fcs_decode(axi_req.wdata[7:0]) == fcs_pkg::CMD_INVALID) begin
                  next_st.res = '0;
                  next_st.res[0] = fcs_pkg::ST0_INVALID;
                  next_st.res_len = 4'd1;
                  next_st.res_idx = 4'd0;
                  next_st.phase = fcs_pkg::PH_RESULT;
                  ev[fcs_pkg::EV_RESULT] = 1'b1;
               end else if (fcs_param_count(fcs_decode(axi_req.wdata[7:0])) == 3'd0) begin
                  next_st.phase = fcs_pkg::PH_EXEC;
               end else begin
                  next_st.phase = fcs_pkg::PH_PARAM;
               end
            end
         end
         fcs_pkg::PH_PARAM: begin
            // Parameter bytes land in order; the last one starts execution
            if (data_wr) begin
               next_st.params[st.pidx] = axi_req.wdata[7:0];
               next_st.pidx = 3'(st.pidx + 3'd1);
               if (3'(st.pidx + 3'd1) == fcs_param_count(st.cmd)) next_st.phase = fcs_pkg::PH_EXEC;
            end
         end
         fcs_pkg::PH_EXEC: begin
            next_st.phase = fcs_pkg::PH_IDLE;
            next_st.res = '0;
            next_st.res_idx = 4'd0;
            case (st.cmd)
               fcs_pkg::CMD_FORMAT: begin
                  next_st.drv = st.params[0][1:0];
                  next_st.head = st.params[0][2];
                  next_st.eot_sc = st.params[2];
                  next_st.fmt_cnt = {st.params[2], 2'b00};
                  next_st.phase = fcs_pkg::PH_FMT;
               end
               fcs_pkg::CMD_RECAL, fcs_pkg::CMD_SEEK: begin
                  next_st.drv = st.params[0][1:0];
                  next_st.head = (st.cmd == fcs_pkg::CMD_SEEK) & st.params[0][2];
                  next_st.target = st.params[1];
                  next_st.recal = (st.cmd == fcs_pkg::CMD_RECAL);
                  next_st.step_cnt = fcs_pkg::STEP_RELOAD;
                  next_st.phase = fcs_pkg::PH_STEP;
               end
               fcs_pkg::CMD_SENSE_INT: begin
                  // Status then cylinder, once per finished seek
                  if (st.seek_pend) begin
                     next_st.res[0] = st.st0_seek;
                     next_st.res[1] = st.present_cylinder_number[st.seek_drv];
                     next_st.res_len = 4'd2;
                     next_st.seek_pend = 1'b0;
                  end else begin
                     next_st.res[0] = fcs_pkg::ST0_INVALID;
                     next_st.res_len = 4'd1;
                  end
                  next_st.phase = fcs_pkg::PH_RESULT;
               end
               fcs_pkg::CMD_SPECIFY: begin
                  next_st.srt_hut = st.params[0];
                  next_st.hlt_nd = st.params[1];
               end
               fcs_pkg::CMD_CONFIGURE: begin
                  next_st.cfg = st.params[1];
                  next_st.precomp_start_track = st.params[2];
               end
               fcs_pkg::CMD_DUMPREG: begin
                  next_st.res[3:0] = st.present_cylinder_number;
                  next_st.res[4] = st.srt_hut;
                  next_st.res[5] = st.hlt_nd;
                  next_st.res[6] = st.eot_sc;
                  next_st.res[7] = {st.lock, 1'b0, st.perp[5:2], st.perp[1], 1'b0};
                  next_st.res[8] = {7'h00, st.perp[0]};
                  next_st.res[9] = st.cfg;
                  next_st.res[10] = st.precomp_start_track;
                  next_st.res_len = fcs_pkg::LEN_DUMPREG;
                  next_st.phase = fcs_pkg::PH_RESULT;
               end
               fcs_pkg::CMD_PERP: next_st.perp = st.params[0];
               fcs_pkg::CMD_LOCK: begin
                  next_st.lock = st.opbyte[7];
                  next_st.res[0] = {3'b000, st.opbyte[7], 4'h0};
                  next_st.res_len = 4'd1;
                  next_st.phase = fcs_pkg::PH_RESULT;
               end
               fcs_pkg::CMD_SENSE_DRIVE: begin
                  next_st.res[0] = {1'b0, drive_in.write_protect, 1'b1, drive_in.track0, 1'b1,
                                    st.params[0][2], st.params[0][1:0]};
                  next_st.res_len = 4'd1;
                  next_st.phase = fcs_pkg::PH_RESULT;
               end
               default: next_st.phase = fcs_pkg::PH_IDLE;
            endcase
            if (next_st.phase == fcs_pkg::PH_RESULT) ev[fcs_pkg::EV_RESULT] = 1'b1;
         end
         fcs_pkg::PH_STEP: begin
            // One step pulse per spacing interval keeps the drive mechanics happy
            if (st.step_cnt != 9'd0) begin
               next_st.step_cnt = 9'(st.step_cnt - 9'd1);
            end else if ((st.recal && drive_in.track0) || (!st.recal && pc == st.target)) begin
               if (st.recal) next_st.present_cylinder_number[st.drv] = 8'h00;
               next_st.seek_pend = 1'b1;
               next_st.st0_seek = fcs_pkg::ST0_SEEK_END | {5'h00, st.head, st.drv};
               next_st.seek_drv = st.drv;
               ev[fcs_pkg::EV_SEEK_END] = 1'b1;
               next_st.phase = fcs_pkg::PH_IDLE;
            end else begin
               next_st.step = 1'b1;
               next_st.dir = !st.recal && (st.target > pc);
               next_st.present_cylinder_number[st.drv] = next_st.dir ? 8'(pc + 8'd1) : 8'(pc - 8'd1);
               next_st.step_cnt = fcs_pkg::STEP_RELOAD;
            end
         end
         fcs_pkg::PH_FMT: begin
            // Four ID bytes per sector, then seven results
            if (st.fmt_cnt == 10'd0) begin
               next_st.res = '0;
               next_st.res[0] = {5'h00, st.head, st.drv};
               next_st.res_len = fcs_pkg::LEN_FORMAT;
               next_st.res_idx = 4'd0;
               next_st.phase = fcs_pkg::PH_RESULT;
               ev[fcs_pkg::EV_RESULT] = 1'b1;
            end else if (data_wr) begin
               next_st.fmt_cnt = 10'(st.fmt_cnt - 10'd1);
            end
         end
         fcs_pkg::PH_RESULT: begin
            if (data_rd) begin
               next_st.res_idx = 4'(st.res_idx + 4'd1);
               if (4'(st.res_idx + 4'd1) == st.res_len) next_st.phase = fcs_pkg::PH_IDLE;
            end
         end
         default: next_st.phase = fcs_pkg::PH_IDLE;
      endcase

      // Sticky events; a new event beats a clear in the same cycle
      next_st.int_status = (st.int_status & ~w1c) | ev;
   end

   // State register with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.phase <= fcs_pkg::PH_IDLE;
         st.cmd <= fcs_pkg::CMD_INVALID;
         st.int_mask <= fcs_pkg::INT_MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_invalid_answer: assert property (
      (st.phase == fcs_pkg::PH_IDLE && data_wr && fcs_decode(axi_req.wdata[7:0]) == fcs_pkg::CMD_INVALID)
      |=> st.phase == fcs_pkg::PH_RESULT && st.res[0] == 8'h80 && st.res_len == 4'd1)
      else $error("invalid opcode answer wrong");
   a_recal_outward: assert property (
      (st.phase == fcs_pkg::PH_STEP && st.recal && st.step) |-> !st.dir)
      else $error("recalibrate stepped inward");
   a_recal_track0: assert property (
      (st.phase == fcs_pkg::PH_STEP && st.recal && st.step_cnt == 9'd0 && drive_in.track0)
      |=> st.phase == fcs_pkg::PH_IDLE && st.present_cylinder_number[st.drv] == 8'h00 && st.int_status[0] && st.seek_pend)
      else $error("recalibrate end wrong");
   a_sense_pair: assert property (
      (st.phase == fcs_pkg::PH_EXEC && st.cmd == fcs_pkg::CMD_SENSE_INT && st.seek_pend)
      |=> st.res_len == 4'd2 && st.res[0] == $past(st.st0_seek) && st.res[1] == $past(st.present_cylinder_number[st.seek_drv]))
      else $error("sense interrupt result wrong");
   a_seek_arrive: assert property (
      (st.phase == fcs_pkg::PH_STEP && !st.recal && st.step_cnt == 9'd0 && st.present_cylinder_number[st.drv] == st.target)
      |=> st.phase == fcs_pkg::PH_IDLE && st.seek_pend && !st.step)
      else $error("seek end wrong");
   a_step_spacing: assert property (
      st.step |=> !st.step [*8])
      else $error("step pulses too close");
   a_dump_order: assert property (
      (st.phase == fcs_pkg::PH_EXEC && st.cmd == fcs_pkg::CMD_DUMPREG)
      |=> st.res_len == 4'd11 && st.res[0] == $past(st.present_cylinder_number[0]) && st.res[10] == $past(st.precomp_start_track))
      else $error("dump registers result wrong");
   a_drive_status: assert property (
      (st.phase == fcs_pkg::PH_EXEC && st.cmd == fcs_pkg::CMD_SENSE_DRIVE)
      |=> st.res_len == 4'd1 && st.res[0][4] == $past(drive_in.track0) && st.phase == fcs_pkg::PH_RESULT)
      else $error("drive status result wrong");
   a_format_results: assert property (
      (st.phase == fcs_pkg::PH_FMT && st.fmt_cnt == 10'd0)
      |=> st.phase == fcs_pkg::PH_RESULT && st.res_len == 4'd7 ##1 st.int_status[1])
      else $error("format results wrong");

   c_invalid: cover property (st.phase == fcs_pkg::PH_RESULT && st.res[0] == 8'h80);
   c_seek_end: cover property (st.phase == fcs_pkg::PH_STEP ##1 st.phase == fcs_pkg::PH_IDLE);
   c_dumpreg: cover property (st.cmd == fcs_pkg::CMD_DUMPREG && st.phase == fcs_pkg::PH_RESULT);
   c_format: cover property (st.phase == fcs_pkg::PH_FMT ##1 st.phase == fcs_pkg::PH_RESULT);
endmodule : fcs_sequencer

// file: rtl/fcs_pkg.sv
// Package for the floppy command sequencer: register map, opcodes, result codes,
// timing counts, bus carriers and the sequencer's state record.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 8-bit byte addresses.
package fcs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_DATA = 8'h00;       // Command bytes in, result bytes out
   localparam logic [7:0] OFF_MAIN_STATUS = 8'h04; // Flow-control status, read only
   localparam logic [7:0] OFF_INT_STATUS = 8'h08;  // Sticky events, write one to clear
   localparam logic [7:0] OFF_INT_MASK = 8'h0c;    // Interrupt enables
   // Main status bit positions
   localparam int MSR_RQM = 7;   // Ready for a data byte
   localparam int MSR_DIO = 6;   // Direction: result byte waiting
   localparam int MSR_BUSY = 4;  // Command in progress
   // Event bit positions
   localparam int EV_SEEK_END = 0;
   localparam int EV_RESULT = 1;
   localparam logic [1:0] INT_MASK_RESET = 2'h0;
   // Opcodes; format and lock carry option bits outside the matched field
   localparam logic [4:0] OP_FORMAT = 5'h0d;
   localparam logic [6:0] OP_LOCK = 7'h14;
   localparam logic [7:0] OP_RECAL = 8'h07;
   localparam logic [7:0] OP_SENSE_INT = 8'h08;
   localparam logic [7:0] OP_SPECIFY = 8'h03;
   localparam logic [7:0] OP_SEEK = 8'h0f;
   localparam logic [7:0] OP_CONFIGURE = 8'h13;
   localparam logic [7:0] OP_DUMPREG = 8'h0e;
   localparam logic [7:0] OP_PERP = 8'h12;
   localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
   // Result codes and lengths
   localparam logic [7:0] ST0_INVALID = 8'h80;
   localparam logic [7:0] ST0_SEEK_END = 8'h20;
   localparam logic [3:0] LEN_DUMPREG = 4'hb;
   localparam logic [3:0] LEN_FORMAT = 4'h7;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Head step spacing: least time, rounded up to whole cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_PERIOD_NS = 3000;
   localparam int STEP_CYCLES = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] STEP_RELOAD = 9'(STEP_CYCLES - 1);

   typedef enum logic [2:0] {PH_IDLE, PH_PARAM, PH_EXEC, PH_STEP, PH_FMT, PH_RESULT} fcs_phase_t;
   typedef enum logic [3:0] {CMD_INVALID, CMD_FORMAT, CMD_RECAL, CMD_SENSE_INT, CMD_SPECIFY, CMD_SEEK,
                             CMD_CONFIGURE, CMD_DUMPREG, CMD_PERP, CMD_LOCK, CMD_SENSE_DRIVE} fcs_cmd_t;

   // Master to slave
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } fcs_axi_req_t;
   // Slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fcs_axi_rsp_t;
   // Drive interface, inputs and outputs
   typedef struct packed {
      logic track0;
      logic write_protect;
   } fcs_drive_in_t;
   typedef struct packed {
      logic step;
      logic dir;          // 1 steps inward
      logic head_select;
      logic [1:0] drive_select;
   } fcs_drive_out_t;

   // Whole state of the sequencer
   typedef struct packed {
      fcs_phase_t phase;
      fcs_cmd_t cmd;
      logic [7:0] opbyte;
      logic [2:0] pidx;
      logic [4:0][7:0] params;
      logic [1:0] drv;
      logic head;
      logic [7:0] target;
      logic recal;
      logic [3:0][7:0] present_cylinder_number;
      logic [8:0] step_cnt;
      logic step;
      logic dir;
      logic seek_pend;
      logic [7:0] st0_seek;
      logic [1:0] seek_drv;
      logic [10:0][7:0] res;
      logic [3:0] res_len;
      logic [3:0] res_idx;
      logic [7:0] srt_hut;
      logic [7:0] hlt_nd;
      logic [7:0] eot_sc;
      logic [7:0] perp;
      logic [7:0] cfg;
      logic [7:0] precomp_start_track;
      logic lock;
      logic [9:0] fmt_cnt;
      logic [1:0] int_status;
      logic [1:0] int_mask;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } fcs_state_t;
endpackage : fcs_pkg

// file: test/fcs_drive_model.sv
// Behavioural drive on the far side of the sequencer's drive pins.
// Assumes one-cycle step pulses, dir high stepping inward.
`timescale 1ns/10ps
module fcs_drive_model #(
   parameter logic WP = 1'b0 // Write protect level
) (
   input wire logic aclk,
   input wire fcs_pkg::fcs_drive_out_t drive_out,
   output fcs_pkg::fcs_drive_in_t drive_in
);
   logic [7:0] cyl = 8'h00; // Head position, one head for all drives
   // Head moves one cylinder per pulse, stops at the outer stop
   always_ff @(posedge aclk) begin
      if (drive_out.step) begin
         cyl <= drive_out.dir ? cyl + 8'h01 : (cyl == 8'h00 ? cyl : cyl - 8'h01);
      end
   end
   assign drive_in.track0 = (cyl == 8'h00);
   assign drive_in.write_protect = WP;
endmodule : fcs_drive_model

// file: test/test_fcs_sequencer.sv
// Self-checking bench for the floppy command sequencer.
// Assumes the drive model on the drive pins; this bench is the bus master.
`timescale 1ns/10ps
module test_fcs_sequencer;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   fcs_pkg::fcs_axi_req_t req = '0; // Master side of the bus
   fcs_pkg::fcs_axi_rsp_t rsp;
   fcs_pkg::fcs_drive_in_t din;
   fcs_pkg::fcs_drive_out_t dout;
   logic irq;
   logic [1:0] resp; // Last response code
   logic [31:0] q; // Last read data
   int mismatches = 0;
   int checks = 0;
   typedef struct {logic [7:0] op; logic [7:0] par; bit has; logic [7:0] exp;} fcs_row_t;
   // Opcode, optional parameter, expected single result
   fcs_row_t rows[4] = '{'{8'hff, 8'h00, 1'b0, 8'h80}, '{8'h08, 8'h00, 1'b0, 8'h80},
                         '{8'h04, 8'h05, 1'b1, 8'h3d}, '{8'h94, 8'h00, 1'b0, 8'h10}};
   // Specify, configure and perpendicular bytes; distinct values so a swapped dump byte shows
   logic [7:0] setup[9] = '{8'h03, 8'ha1, 8'hb2, 8'h13, 8'h00, 8'hc4, 8'h37, 8'h12, 8'h2b};
   // Dump expected after the seek: cylinders, specify, sectors, lock and perpendicular, configure
   logic [7:0] dump_exp[11] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'ha1, 8'hb2, 8'h00, 8'haa, 8'h01, 8'hc4, 8'h37};
   fcs_sequencer DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
                      .drive_in(din), .drive_out(dout), .irq(irq));
   fcs_drive_model model (.aclk(aclk), .drive_out(dout), .drive_in(din));
   // 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // One bus transfer; mid-cycle sampling equals the next edge's view
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      req <= '{awvalid: w, awaddr: a, wvalid: w, wdata: d, wstrb: 4'hf, bready: w,
               arvalid: !w, araddr: a, rready: !w};
      do @(negedge aclk); while (w ? !rsp.awready : !rsp.arready);
      @(posedge aclk);
      req.awvalid <= 1'b0;
      req.wvalid <= 1'b0;
      req.arvalid <= 1'b0;
      do @(negedge aclk); while (w ? !rsp.bvalid : !rsp.rvalid);
      resp = w ? rsp.bresp : rsp.rresp;
      q = rsp.rdata;
      @(posedge aclk);
      req.bready <= 1'b0;
      req.rready <= 1'b0;
   endtask : bus
   // Command byte into the data port
   task automatic send(input logic [7:0] b);
      bus(1'b1, fcs_pkg::OFF_DATA, {24'h0, b});
   endtask : send
   // Pop one result byte and compare
   task automatic res(input logic [7:0] e);
      bus(1'b0, fcs_pkg::OFF_DATA, 32'h0);
      chk(q, {24'h0, e});
   endtask : res
   // Bounded wait for the interrupt line
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      chk(irq, 1'b1);
   endtask : wait_irq
   // Verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // Watchdog, well past the few thousand cycles needed
   initial begin
      repeat (30000) @(posedge aclk);
      mismatches++;
      complete_run();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b0, fcs_pkg::OFF_MAIN_STATUS, 32'h0);
      chk(q[fcs_pkg::MSR_BUSY], 1'b0);
      bus(1'b0, fcs_pkg::OFF_INT_MASK, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h10, 32'h0); // Unmapped place
      chk(resp, fcs_pkg::RESP_SLVERR);
      bus(1'b1, fcs_pkg::OFF_INT_MASK, 32'h1); // Seek end only
      $display("reset test done");
      foreach (rows[i]) begin
         send(rows[i].op);
         if (rows[i].has) begin
            send(rows[i].par);
         end
         res(rows[i].exp);
      end
      chk(irq, 1'b0);
      $display("table test done");
      // seek drive 1, head 1 to cylinder 3
      send(fcs_pkg::OP_SEEK);
      send(8'h05);
      send(8'h03);
      wait_irq();
      chk(dout.drive_select, 2'h1);
      chk(dout.head_select, 1'b1);
      chk(din.track0, 1'b0);
      send(fcs_pkg::OP_SENSE_INT);
      res(8'h25);
      res(8'h03);
      bus(1'b1, fcs_pkg::OFF_INT_STATUS, 32'h3);
      chk(irq, 1'b0);
      // settings first, then every dump byte in order
      foreach (setup[i]) send(setup[i]);
      send(fcs_pkg::OP_DUMPREG);
      foreach (dump_exp[i]) res(dump_exp[i]);
      $display("seek test done");
      send(fcs_pkg::OP_RECAL);
      send(8'h01);
      wait_irq();
      chk(din.track0, 1'b1);
      send(fcs_pkg::OP_SENSE_INT);
      res(8'h21);
      res(8'h00);
      bus(1'b1, fcs_pkg::OFF_INT_STATUS, 32'h3);
      $display("recal test done");
      send({3'h0, fcs_pkg::OP_FORMAT});
      send(8'h01);
      send(8'h02);
      send(8'h01);
      send(8'h1b);
      send(8'he5);
      for (int i = 0; i < 4; i++) send(8'(i));
      res(8'h01);
      for (int i = 0; i < 6; i++) res(8'h00);
      bus(1'b0, fcs_pkg::OFF_MAIN_STATUS, 32'h0);
      chk(q[fcs_pkg::MSR_BUSY], 1'b0);
      $display("format test done");
      // Reset in mid-seek drops the command and all state
      send(fcs_pkg::OP_SEEK);
      send(8'h02);
      send(8'h07);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk(irq, 1'b0);
      chk(dout, 32'h0);
      bus(1'b0, fcs_pkg::OFF_MAIN_STATUS, 32'h0);
      chk(q[fcs_pkg::MSR_BUSY], 1'b0);
      send(8'hff);
      res(8'h80);
      $display("mid-run reset test done");
      complete_run();
   end
endmodule : test_fcs_sequencer
